// File: rtl/sar_pkg.sv
// shared constants, types and helpers for the sdram activate/read link
`default_nettype none
package sar_pkg;
   // ----------------------------------------
   // geometry and clock
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int BA_W = 2;
   localparam int ROW_W = 12;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int NBANK = 4;
   localparam int MEM_ROW_W = 4;
   // ----------------------------------------
   // timing, in ns and in cycles
   // ----------------------------------------
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS = 20;
   localparam int T_RC_NS = 66;
   localparam int T_RRD_NS = 15;
   function automatic int sar_ns2cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction
   localparam logic [7:0] RCD_CYC = 8'(sar_ns2cyc(T_RCD_NS));
   localparam logic [7:0] RP_CYC = 8'(sar_ns2cyc(T_RP_NS));
   localparam logic [7:0] RC_CYC = 8'(sar_ns2cyc(T_RC_NS));
   localparam logic [7:0] RRD_CYC = 8'(sar_ns2cyc(T_RRD_NS));
   // ----------------------------------------
   // mode word fields
   // ----------------------------------------
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BT_BIT = 3;
   localparam int MODE_CL_LSB = 4;
   localparam int MODE_OP_LSB = 7;
   localparam int MODE_WBM_BIT = 9;
   localparam int AP_BIT = 10;
   localparam logic [2:0] CL_TWO = 3'h2;
   localparam logic [2:0] CL_THREE = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [1:0] OP_NORMAL = 2'h0;
   localparam logic [11:0] MODE_RST = 12'h020;
   // ----------------------------------------
   // commands, {ras_b, cas_b, we_b}
   // ----------------------------------------
   typedef enum logic [2:0] {
      CMD_LMR = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
      CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
   } sar_cmd_t;
   // ----------------------------------------
   // controller register map
   // ----------------------------------------
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int CMD_BA_LSB = 3;
   localparam int CMD_AP_BIT = 5;
   localparam int CMD_ADDR_LSB = 16;
   // ----------------------------------------
   // burst helpers
   // ----------------------------------------
   function automatic logic [9:0] sar_burst_len(input logic [2:0] code);
      return (code == BL_FULL) ? 10'h200 : 10'(10'h1 << code[1:0]);
   endfunction
   function automatic logic [COL_W-1:0] sar_burst_col(input logic [COL_W-1:0] start,
         input logic [9:0] cnt, input logic [2:0] code, input logic bt);
      logic [COL_W-1:0] m;
      logic [COL_W-1:0] off;
      m = (code == BL_FULL) ? '1 : 9'(sar_burst_len(code) - 10'h1);
      off = (bt && code != BL_FULL) ? (start ^ cnt[COL_W-1:0]) : (start + cnt[COL_W-1:0]);
      return (start & ~m) | (off & m);
   endfunction
endpackage
`default_nettype wire

// File: rtl/sar_if.sv
// command, address, mask and data wires between controller and dram
`default_nettype none
interface sar_if;
   logic ras_b;
   logic cas_b;
   logic we_b;
   logic [1:0] ba;
   logic [11:0] addr;
   logic dqm;
   logic [15:0] ctl_dq_out;
   logic ctl_dq_oe;
   logic [15:0] dev_dq_out;
   logic dev_dq_oe;
   logic [15:0] dq;
   // the dram wins while it drives; contention is the bench's to flag
   assign dq = dev_dq_oe ? dev_dq_out : ctl_dq_out;
   modport dev (input ras_b, input cas_b, input we_b, input ba, input addr, input dqm,
      input dq, output dev_dq_out, output dev_dq_oe);
   modport ctl (output ras_b, output cas_b, output we_b, output ba, output addr,
      output dqm, output ctl_dq_out, output ctl_dq_oe, input dq, input dev_dq_oe);
endinterface
`default_nettype wire

// File: rtl/sar_dram.sv
// dram end: mode, bank/row state, burst engine and read data pipe
`default_nettype none
module sar_dram (
   input wire logic clock,
   input wire logic rst_b,
   sar_if.dev link,
   output logic [3:0] bank_open,
   output logic timing_err,
   output logic mode_err
);
   import sar_pkg::*;

   typedef struct packed {
      logic [2:0] bl;
      logic bt;
      logic [2:0] cl;
      logic wbm;
      logic [3:0] open;
      logic [3:0][ROW_W-1:0] row;
      logic [3:0][7:0] act_cnt;
      logic [3:0][7:0] pre_cnt;
      logic [7:0] rrd_cnt;
      logic gen_on;
      logic gen_wr;
      logic gen_ap;
      logic [BA_W-1:0] gen_bank;
      logic [COL_W-1:0] gen_start;
      logic [9:0] gen_cnt;
      logic wr_ok;
      logic ap_due;
      logic [BA_W-1:0] ap_bank;
      logic dqm_d;
      logic [1:0] pv;
      logic [1:0][DQ_W-1:0] pd;
      logic dq_oe;
      logic [DQ_W-1:0] dq;
      logic viol;
      logic mode_err;
   } sar_dev_st_t;

   sar_dev_st_t st_ff;
   sar_dev_st_t nxt_st;
   logic [DQ_W-1:0] mem [0:(1 << (BA_W + MEM_ROW_W + COL_W)) - 1];
   sar_cmd_t cmd;
   logic elem_on;
   logic elem_wr;
   logic elem_ok;
   logic [BA_W-1:0] elem_bank;
   logic [COL_W-1:0] elem_col;
   logic [BA_W+MEM_ROW_W+COL_W-1:0] elem_idx;
   logic [9:0] len;
   logic stop;
   logic reading;

   assign cmd = sar_cmd_t'({link.ras_b, link.cas_b, link.we_b});

   always_comb
   begin
      nxt_st = st_ff;
      elem_on = 1'b0;
      elem_wr = 1'b0;
      elem_ok = 1'b0;
      elem_bank = st_ff.gen_bank;
      elem_col = '0;
      len = 10'h1;
      nxt_st.viol = 1'b0;
      nxt_st.mode_err = 1'b0;
      nxt_st.dqm_d = link.dqm;
      reading = (st_ff.gen_on && !st_ff.gen_wr) || (st_ff.pv != 2'h0) || st_ff.dq_oe;
      // ----------------------------------------
      // per-bank timers
      // ----------------------------------------
      for (int b = 0; b < NBANK; b++)
      begin
         if (st_ff.act_cnt[b] != 8'hFF)
            nxt_st.act_cnt[b] = st_ff.act_cnt[b] + 8'h1;
         if (st_ff.pre_cnt[b] != 8'h0)
            nxt_st.pre_cnt[b] = st_ff.pre_cnt[b] - 8'h1;
      end
      if (st_ff.rrd_cnt != 8'h0)
         nxt_st.rrd_cnt = st_ff.rrd_cnt - 8'h1;
      // auto precharge lands one edge after the last element, as an optimum precharge would
      if (st_ff.ap_due)
      begin
         nxt_st.ap_due = 1'b0;
         nxt_st.open[st_ff.ap_bank] = 1'b0;
         nxt_st.pre_cnt[st_ff.ap_bank] = RP_CYC - 8'h1;
      end
      // ----------------------------------------
      // command decode
      // ----------------------------------------
      stop = (cmd == CMD_BST) ||
         (cmd == CMD_PRE && (link.addr[AP_BIT] || link.ba == st_ff.gen_bank));
      unique case (cmd)
         CMD_LMR:
         begin
            if (link.addr[MODE_CL_LSB +: 3] inside {CL_TWO, CL_THREE} &&
                link.addr[MODE_OP_LSB +: 2] == OP_NORMAL)
            begin
               nxt_st.bl = link.addr[MODE_BL_LSB +: 3];
               nxt_st.bt = link.addr[MODE_BT_BIT];
               nxt_st.cl = link.addr[MODE_CL_LSB +: 3];
               nxt_st.wbm = link.addr[MODE_WBM_BIT];
            end
            else
               nxt_st.mode_err = 1'b1;
         end
         CMD_ACT:
         begin
            if (st_ff.open[link.ba] || st_ff.pre_cnt[link.ba] != 8'h0 ||
                st_ff.act_cnt[link.ba] < RC_CYC || st_ff.rrd_cnt != 8'h0)
               nxt_st.viol = 1'b1;
            nxt_st.open[link.ba] = 1'b1;
            nxt_st.row[link.ba] = link.addr;
            nxt_st.act_cnt[link.ba] = 8'h1;
            nxt_st.rrd_cnt = RRD_CYC - 8'h1;
         end
         CMD_PRE:
         begin
            for (int b = 0; b < NBANK; b++)
               if (link.addr[AP_BIT] || link.ba == BA_W'(b))
               begin
                  nxt_st.open[b] = 1'b0;
                  nxt_st.pre_cnt[b] = RP_CYC - 8'h1;
               end
         end
         CMD_RD, CMD_WR:
         begin
            if (!st_ff.open[link.ba] || st_ff.act_cnt[link.ba] < RCD_CYC)
               nxt_st.viol = 1'b1;
            elem_wr = (cmd == CMD_WR);
            len = (elem_wr && st_ff.wbm) ? 10'h1 : sar_burst_len(st_ff.bl);
            elem_on = 1'b1;
            elem_bank = link.ba;
            elem_col = link.addr[COL_W-1:0];
            // a masked-out read ahead of the write keeps this write valid
            elem_ok = !(elem_wr && reading && !st_ff.dqm_d);
            nxt_st.wr_ok = elem_ok;
            if (st_ff.gen_on && st_ff.gen_ap)
            begin
               nxt_st.ap_due = 1'b1;
               nxt_st.ap_bank = st_ff.gen_bank;
            end
            // any burst read or write restarts the engine on any cycle
            nxt_st.gen_on = (len != 10'h1) || (st_ff.bl == BL_FULL && !(elem_wr && st_ff.wbm));
            nxt_st.gen_wr = elem_wr;
            nxt_st.gen_ap = link.addr[AP_BIT] && st_ff.bl != BL_FULL;
            nxt_st.gen_bank = link.ba;
            nxt_st.gen_start = link.addr[COL_W-1:0];
            nxt_st.gen_cnt = 10'h1;
            if (len == 10'h1 && link.addr[AP_BIT])
            begin
               nxt_st.ap_due = 1'b1;
               nxt_st.ap_bank = link.ba;
            end
         end
         default:
         begin
            if (st_ff.gen_on && !stop)
            begin
               len = (st_ff.gen_wr && st_ff.wbm) ? 10'h1 : sar_burst_len(st_ff.bl);
               elem_on = 1'b1;
               elem_wr = st_ff.gen_wr;
               elem_ok = st_ff.wr_ok;
               // fixed bursts wrap in their block, full page wraps at the page end
               elem_col = sar_burst_col(st_ff.gen_start, st_ff.gen_cnt, st_ff.bl,
                  st_ff.bt);
               nxt_st.gen_cnt = st_ff.gen_cnt + 10'h1;
               if (st_ff.bl != BL_FULL && st_ff.gen_cnt + 10'h1 == len)
               begin
                  nxt_st.gen_on = 1'b0;
                  if (st_ff.gen_ap)
                  begin
                     nxt_st.ap_due = 1'b1;
                     nxt_st.ap_bank = st_ff.gen_bank;
                  end
               end
            end
         end
      endcase
      if (stop)
         nxt_st.gen_on = 1'b0;
      // ----------------------------------------
      // read data pipe and output mask
      // ----------------------------------------
      elem_idx = {elem_bank, st_ff.row[elem_bank][MEM_ROW_W-1:0], elem_col};
      nxt_st.pv = {st_ff.pv[0], elem_on && !elem_wr};
      nxt_st.pd = {st_ff.pd[0], mem[elem_idx]};
      // cl three takes one more stage, so data is driven after n+m-1
      nxt_st.dq = (st_ff.cl == CL_THREE) ? st_ff.pd[1] : st_ff.pd[0];
      // mask taken one edge back gives the two-clock output latency
      nxt_st.dq_oe = ((st_ff.cl == CL_THREE) ? st_ff.pv[1] : st_ff.pv[0]) &&
         !st_ff.dqm_d;
      if (cmd == CMD_WR)
      begin
         nxt_st.pv = 2'h0;
         nxt_st.dq_oe = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
         st_ff.bl <= MODE_RST[MODE_BL_LSB +: 3];
         st_ff.cl <= MODE_RST[MODE_CL_LSB +: 3];
         st_ff.act_cnt <= {NBANK{8'hFF}};
      end
      else
         st_ff <= nxt_st;
   end

   // storage only; the input mask acts on the same edge as the data
   always_ff @(posedge clock)
   begin
      if (elem_on && elem_wr && elem_ok && !link.dqm)
         mem[elem_idx] <= link.dq;
   end

   assign link.dev_dq_out = st_ff.dq;
   assign link.dev_dq_oe = st_ff.dq_oe;
   assign bank_open = st_ff.open;
   assign timing_err = st_ff.viol;
   assign mode_err = st_ff.mode_err;
endmodule
`default_nettype wire

// File: rtl/sar_ctl.sv
// controller end: apb registers, command spacing, write data and read capture
//
// The APB register port and the register addresses were decided locally.
`default_nettype none
module sar_ctl (
   input wire logic clock,
   input wire logic rst_b,
   sar_if.ctl link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import sar_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_HOLD = 4'b0010, ST_MASK = 4'b0100, ST_WBURST = 4'b1000
   } sar_ctl_state_t;

   typedef struct packed {
      sar_ctl_state_t state;
      sar_cmd_t pend_op;
      logic [BA_W-1:0] pend_ba;
      logic [ROW_W-1:0] pend_addr;
      logic [2:0] bl;
      logic [2:0] cl;
      logic wbm;
      logic [DQ_W-1:0] wdata;
      logic [DQ_W-1:0] rdata;
      logic [15:0] rcount;
      logic [3:0] open;
      logic [3:0][7:0] act_cnt;
      logic [3:0][7:0] pre_cnt;
      logic [7:0] rrd_cnt;
      logic [7:0] rd_busy;
      logic page_rd;
      logic [9:0] cnt;
      sar_cmd_t cmd;
      logic [BA_W-1:0] ba;
      logic [ROW_W-1:0] addr;
      logic dqm;
      logic dq_oe;
   } sar_ctl_st_t;

   sar_ctl_st_t st_ff;
   sar_ctl_st_t nxt_st;
   logic acc;
   logic launch;
   logic mode_ok;
   logic legal;
   logic busy;

   assign busy = (st_ff.state != ST_IDLE);
   assign acc = psel && penable;
   assign launch = pwrite && (paddr == REG_CMD || paddr == REG_MODE);
   assign mode_ok = pwdata[MODE_CL_LSB +: 3] inside {CL_TWO, CL_THREE} &&
      pwdata[MODE_OP_LSB +: 2] == OP_NORMAL;
   assign pready = !(busy && launch);
   assign pslverr = acc && pready &&
      (!(paddr inside {REG_CMD, REG_MODE, REG_WDATA, REG_RDATA, REG_STATUS}) ||
       (pwrite && paddr == REG_MODE && !mode_ok));

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.cmd = CMD_NOP;
      nxt_st.dqm = 1'b0;
      legal = 1'b0;
      for (int b = 0; b < NBANK; b++)
      begin
         if (st_ff.act_cnt[b] != 8'hFF)
            nxt_st.act_cnt[b] = st_ff.act_cnt[b] + 8'h1;
         if (st_ff.pre_cnt[b] != 8'h0)
            nxt_st.pre_cnt[b] = st_ff.pre_cnt[b] - 8'h1;
      end
      if (st_ff.rrd_cnt != 8'h0)
         nxt_st.rrd_cnt = st_ff.rrd_cnt - 8'h1;
      if (st_ff.page_rd)
         nxt_st.rd_busy = 8'hFF;
      else if (st_ff.rd_busy != 8'h0)
         nxt_st.rd_busy = st_ff.rd_busy - 8'h1;
      if (link.dev_dq_oe)
      begin
         nxt_st.rdata = link.dq;
         nxt_st.rcount = st_ff.rcount + 16'h1;
      end
      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (acc && pready && pwrite && !pslverr)
      begin
         unique case (paddr)
            REG_CMD:
            begin
               nxt_st.pend_op = sar_cmd_t'(pwdata[2:0]);
               nxt_st.pend_ba = pwdata[CMD_BA_LSB +: BA_W];
               nxt_st.pend_addr = pwdata[CMD_ADDR_LSB +: ROW_W];
               if (pwdata[2:0] inside {CMD_RD, CMD_WR})
                  nxt_st.pend_addr[AP_BIT] = pwdata[CMD_AP_BIT];
               nxt_st.state = ST_HOLD;
            end
            REG_MODE:
            begin
               nxt_st.pend_op = CMD_LMR;
               nxt_st.pend_ba = '0;
               nxt_st.pend_addr = pwdata[ROW_W-1:0];
               nxt_st.state = ST_HOLD;
            end
            REG_WDATA:
               nxt_st.wdata = pwdata[DQ_W-1:0];
            default:
               nxt_st.wdata = st_ff.wdata;
         endcase
      end
      // ----------------------------------------
      // spacing and issue
      // ----------------------------------------
      unique case (st_ff.pend_op)
         CMD_ACT:
            legal = !st_ff.open[st_ff.pend_ba] && st_ff.pre_cnt[st_ff.pend_ba] == 8'h0 &&
               st_ff.act_cnt[st_ff.pend_ba] >= RC_CYC && st_ff.rrd_cnt == 8'h0;
         CMD_RD, CMD_WR:
            legal = st_ff.open[st_ff.pend_ba] &&
               st_ff.act_cnt[st_ff.pend_ba] >= RCD_CYC;
         CMD_LMR:
            legal = (st_ff.open == 4'h0) && (st_ff.rd_busy == 8'h0);
         default:
            legal = 1'b1;
      endcase
      unique case (st_ff.state)
         ST_IDLE:
            nxt_st.dq_oe = 1'b0;
         ST_HOLD:
         begin
            if (legal && st_ff.pend_op == CMD_WR && st_ff.rd_busy != 8'h0)
            begin
               nxt_st.dqm = 1'b1;
               nxt_st.cnt = 10'h1;
               nxt_st.state = ST_MASK;
            end
            else if (legal)
            begin
               nxt_st.cmd = st_ff.pend_op;
               nxt_st.ba = st_ff.pend_ba;
               nxt_st.addr = st_ff.pend_addr;
               nxt_st.state = ST_IDLE;
               unique case (st_ff.pend_op)
                  CMD_ACT:
                  begin
                     nxt_st.open[st_ff.pend_ba] = 1'b1;
                     nxt_st.act_cnt[st_ff.pend_ba] = 8'h1;
                     nxt_st.rrd_cnt = RRD_CYC - 8'h1;
                  end
                  CMD_PRE:
                  begin
                     for (int b = 0; b < NBANK; b++)
                        if (st_ff.pend_addr[AP_BIT] || st_ff.pend_ba == BA_W'(b))
                        begin
                           nxt_st.open[b] = 1'b0;
                           nxt_st.pre_cnt[b] = RP_CYC - 8'h1;
                        end
                     nxt_st.page_rd = 1'b0;
                     nxt_st.rd_busy = {5'h0, st_ff.cl};
                  end
                  CMD_BST:
                  begin
                     nxt_st.page_rd = 1'b0;
                     nxt_st.rd_busy = {5'h0, st_ff.cl};
                  end
                  CMD_LMR:
                  begin
                     nxt_st.bl = st_ff.pend_addr[MODE_BL_LSB +: 3];
                     nxt_st.cl = st_ff.pend_addr[MODE_CL_LSB +: 3];
                     nxt_st.wbm = st_ff.pend_addr[MODE_WBM_BIT];
                  end
                  CMD_RD:
                  begin
                     nxt_st.page_rd = (st_ff.bl == BL_FULL);
                     nxt_st.rd_busy = 8'(sar_burst_len(st_ff.bl)) + {5'h0, st_ff.cl};
                     if (st_ff.pend_addr[AP_BIT] && st_ff.bl != BL_FULL)
                        nxt_st.open[st_ff.pend_ba] = 1'b0;
                  end
                  default:
                     nxt_st.cmd = st_ff.pend_op;
               endcase
            end
         end
         ST_MASK:
         begin
            if (st_ff.cnt != 10'h0)
            begin
               nxt_st.dqm = 1'b1;
               nxt_st.cnt = 10'h0;
            end
            else
               nxt_st.state = ST_WBURST;
         end
         ST_WBURST:
         begin
            if (st_ff.cnt != 10'h0)
               nxt_st.cnt = st_ff.cnt - 10'h1;
            else
            begin
               nxt_st.dq_oe = 1'b0;
               nxt_st.state = ST_IDLE;
            end
         end
         default:
            nxt_st.state = ST_IDLE;
      endcase
      // write goes out with the mask low so its own data is taken
      if ((st_ff.state == ST_HOLD && legal && st_ff.pend_op == CMD_WR &&
           st_ff.rd_busy == 8'h0) || (st_ff.state == ST_MASK && st_ff.cnt == 10'h0))
      begin
         nxt_st.cmd = CMD_WR;
         nxt_st.ba = st_ff.pend_ba;
         nxt_st.addr = st_ff.pend_addr;
         nxt_st.dqm = 1'b0;
         nxt_st.dq_oe = 1'b1;
         nxt_st.page_rd = 1'b0;
         nxt_st.rd_busy = 8'h0;
         nxt_st.cnt = st_ff.wbm ? 10'h0 : sar_burst_len(st_ff.bl) - 10'h1;
         nxt_st.state = ST_WBURST;
         if (st_ff.pend_addr[AP_BIT] && st_ff.bl != BL_FULL)
            nxt_st.open[st_ff.pend_ba] = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
         st_ff.state <= ST_IDLE;
         st_ff.pend_op <= CMD_NOP;
         st_ff.cmd <= CMD_NOP;
         st_ff.bl <= MODE_RST[MODE_BL_LSB +: 3];
         st_ff.cl <= MODE_RST[MODE_CL_LSB +: 3];
         st_ff.act_cnt <= {NBANK{8'hFF}};
      end
      else
         st_ff <= nxt_st;
   end

   always_comb
   begin
      unique case (paddr)
         REG_RDATA:
            prdata = {st_ff.rcount, st_ff.rdata};
         REG_STATUS:
            prdata = {27'h0, st_ff.open, busy};
         default:
            prdata = 32'h0;
      endcase
   end

   assign {link.ras_b, link.cas_b, link.we_b} = st_ff.cmd;
   assign link.ba = st_ff.ba;
   assign link.addr = st_ff.addr;
   assign link.dqm = st_ff.dqm;
   assign link.ctl_dq_out = st_ff.wdata;
   assign link.ctl_dq_oe = st_ff.dq_oe;
endmodule
`default_nettype wire

// File: testbench/sar_props.sv
// assertions on the wires between controller and dram
`default_nettype none
module sar_props (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ras_b,
   input wire logic cas_b,
   input wire logic we_b,
   input wire logic [1:0] ba,
   input wire logic [11:0] addr,
   input wire logic dqm,
   input wire logic ctl_dq_oe,
   input wire logic dev_dq_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   import sar_pkg::*;
   logic [2:0] cmd;
   logic [6:0] mode_ff;
   logic rd, c2, c3;
   assign cmd = {ras_b, cas_b, we_b};
   assign rd = (cmd == CMD_RD);
   // exact data windows only for cl2 single beat and cl3 two-beat sequential modes
   assign c2 = (mode_ff == 7'h20);
   assign c3 = (mode_ff == 7'h31);
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         mode_ff <= 7'h20;
      else if (cmd == CMD_LMR)
         mode_ff <= addr[6:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_RD_CL2: assert property ((rd && c2 && !dqm) ##1 cmd == CMD_NOP
      |=> dev_dq_oe ##1 !dev_dq_oe)
      else $error("cl2 read window wrong");
   AST_RD_CL3: assert property ((rd && c3 && !dqm) ##1 (cmd == CMD_NOP && !dqm)
      ##1 (cmd == CMD_NOP && !dqm) |=> dev_dq_oe ##1 dev_dq_oe ##1 !dev_dq_oe)
      else $error("cl3 read window wrong");
   AST_NO_FIGHT: assert property (!(dev_dq_oe && ctl_dq_oe))
      else $error("both ends drive dq");
   AST_ACTIVATE_TO_ACCESS_DELAY: assert property (cmd == CMD_ACT ##1 (rd || cmd == CMD_WR)
      |-> ba != $past(ba))
      else $error("access too soon after activate");
   AST_BANK_TO_BANK_ACTIVATE_INTERVAL: assert property (cmd == CMD_ACT |=> cmd != CMD_ACT)
      else $error("activates too close");
   AST_TRP: assert property (cmd == CMD_PRE ##1 cmd == CMD_ACT
      |-> !$past(addr[10]) && ba != $past(ba))
      else $error("activate inside precharge period");
   AST_MASK: assert property (dqm |-> ##2 !dev_dq_oe)
      else $error("masked element driven");
   AST_WR_QUIET: assert property (cmd == CMD_WR |=> !dev_dq_oe)
      else $error("dram drives after write");
   AST_WR_DATA: assert property (cmd == CMD_WR |-> ctl_dq_oe && !dqm)
      else $error("write data masked or undriven");
   cover property (rd && c3);
   cover property (dqm ##2 cmd == CMD_WR);
   cover property (cmd == CMD_PRE);
endmodule
`default_nettype wire

// File: testbench/tb_sdram_activate_read_timing.sv
// bench: apb-driven controller facing the dram end
`default_nettype none
module tb_sdram_activate_read_timing;
   timeunit 1ns;
   timeprecision 1ns;
   import sar_pkg::*;
   logic clock, te, me, pready, pslverr, er;
   logic rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] bo;
   int n_mismatch, checked, cyc;
   localparam logic [32:0] ERR = 33'h1_0000_0000;
   sar_if link();
   sar_ctl sar_ctl_i (.clock, .rst_b, .link(link.ctl), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   sar_dram sar_dram_i (.clock, .rst_b, .link(link.dev), .bank_open(bo), .timing_err(te),
      .mode_err(me));
   sar_props sar_props_i (.clock, .rst_b, .ras_b(link.ras_b), .cas_b(link.cas_b),
      .we_b(link.we_b), .ba(link.ba), .addr(link.addr), .dqm(link.dqm),
      .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one apb transfer, then an idle cycle so psel never toggles twice in a step
   task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [32:0] e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
      chk({er, w ? 32'h0 : rd}, e);
   endtask
   function automatic logic [31:0] cw(input sar_cmd_t op, input logic [1:0] b,
         input logic [11:0] a);
      return {4'h0, a, 11'h0, b, op};
   endfunction
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   always @(negedge clock)
      if (rst_b)
         chk({31'h0, te, me}, '0);
   initial
   begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      io(1'b0, REG_STATUS, '0, '0);
      io(1'b0, 8'h14, '0, ERR);
      io(1'b1, REG_MODE, 32'h0000_0040, ERR);
      io(1'b1, REG_MODE, 32'h0000_00a0, ERR);
      io(1'b1, REG_MODE, 32'h0000_0020, '0);
      io(1'b1, REG_CMD, cw(CMD_ACT, 2'h1, 12'h003), '0);
      io(1'b1, REG_WDATA, 32'h0000_beef, '0);
      io(1'b1, REG_CMD, cw(CMD_WR, 2'h1, 12'h005), '0);
      io(1'b1, REG_CMD, cw(CMD_RD, 2'h1, 12'h005), '0);
      repeat (8) @(posedge clock);
      io(1'b0, REG_RDATA, '0, 33'h0_0001_beef);
      chk(33'(bo), 33'h0_0000_0002);
      io(1'b1, REG_CMD, cw(CMD_PRE, 2'h1, 12'h000), '0);
      io(1'b1, REG_MODE, 32'h0000_0231, '0);
      chk(33'(bo), '0);
      io(1'b1, REG_CMD, cw(CMD_ACT, 2'h2, 12'h001), '0);
      io(1'b1, REG_WDATA, 32'h0000_1111, '0);
      io(1'b1, REG_CMD, cw(CMD_WR, 2'h2, 12'h008), '0);
      io(1'b1, REG_WDATA, 32'h0000_2222, '0);
      io(1'b1, REG_CMD, cw(CMD_WR, 2'h2, 12'h009), '0);
      io(1'b1, REG_CMD, cw(CMD_RD, 2'h2, 12'h009), '0);
      repeat (8) @(posedge clock);
      io(1'b0, REG_RDATA, '0, 33'h0_0003_1111);
      io(1'b1, REG_CMD, cw(CMD_RD, 2'h2, 12'h008), '0);
      io(1'b1, REG_CMD, cw(CMD_WR, 2'h2, 12'h007), '0);
      repeat (8) @(posedge clock);
      io(1'b0, REG_RDATA, '0, 33'h0_0005_2222);
      io(1'b1, REG_CMD, cw(CMD_BST, 2'h2, 12'h000), '0);
      repeat (8) @(posedge clock);
      io(1'b0, REG_STATUS, '0, 33'h0_0000_0008);
      print_verdict();
   end
endmodule
`default_nettype wire
